// >>> adc_seq_pkg.sv
// Constants, register layouts, types and helper functions of the converter sequencer.
// ==========================================================================
// Summary of operation
// [RULE_01] Eight-bit channel mask picks inputs; an all-zero mask acts as input 0 only.
// [RULE_02] Software single conversions should select exactly one input in the mask.
// [RULE_03] Continuous scan accepts one to eight selected inputs, converted in turn.
// [RULE_04] Conversion clock is the bus clock divided by divisor field plus one.
// [RULE_05] Software picks the smallest divisor keeping conversion clock at most 4.5 MHz.
// [RULE_06] Scan bit clear: conversions start by software or trigger, 11 clocks each.
// [RULE_07] Scan bit set: back-to-back conversions at resolution-code length over selected inputs.
// [RULE_08] Scan starts at lowest selected input, then moves to higher selected inputs.
// [RULE_09] Clearing scan bit stops repeats; the running conversion still completes.
// [RULE_10] Resolution code 000 is 11 clocks and 10 bits; each step removes one each.
// [RULE_11] Power bit 1 keeps converter operational; 0 holds it powered down.
// [RULE_12] Trigger code 000 starts nothing; software writes it when powering down.
// [RULE_13] Writing trigger code 001 with scan bit clear starts a conversion immediately.
// [RULE_14] Codes 010 and 011 start on the selected edge of trigger pin A or B.
// [RULE_15] Codes 100 to 111 start on the selected edge of four timer match signals.
// [RULE_16] Trigger source field is acted on only while scan bit is clear.
// [RULE_17] Polarity bit picks edge for codes 010-111: 0 falling, 1 rising.
// [RULE_18] Test field: 00 normal, 01 digital test, 10 converter test, 11 simple test.
// [RULE_19] Completion flag sets on finish, clears on result read or control write.
// [RULE_20] Edge detection works on selected signal XORed with the polarity bit.
// [RULE_21] Each result is reported with the three-bit channel number that produced it.
// [RULE_22] Interrupt request stays asserted while the completion flag is set.
// [RULE_23] Scan wraps from highest selected input back to the lowest and continues.
package adc_seq_pkg;

	// ======================================================================
	// Register map
	localparam logic [31:0] CTRL_ADDR   = 32'he003_4000;
	localparam logic [31:0] RESULT_ADDR = 32'he003_4004;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
	localparam logic [31:0] CTRL_WMASK  = 32'h0fef_ffff;

	typedef enum logic [1:0] {
		TEST_NORMAL,
		TEST_DIGITAL,
		TEST_CONVERTER,
		TEST_SIMPLE
	} test_mode_t;

	typedef struct packed {
		logic [3:0] rsv_hi;
		logic       edge_rising;
		logic [2:0] trigger_source;
		test_mode_t test_mode_field;
		logic       converter_powered;
		logic       rsv_mid;
		logic [2:0] scan_resolution_code;
		logic       continuous_scan;
		logic [7:0] conv_clock_divisor;
		logic [7:0] channel_mask;
	} ctrl_t;

	typedef struct packed {
		logic       done;
		logic       overrun;
		logic [2:0] rsv_hi;
		logic [2:0] result_channel;
		logic [7:0] rsv_mid;
		logic [9:0] data;
		logic [5:0] rsv_lo;
	} result_t;

	// ======================================================================
	// Trigger codes and timing
	localparam logic [2:0] TRIG_NONE        = 3'h0;
	localparam logic [2:0] TRIG_NOW         = 3'h1;
	localparam logic [2:0] TRIG_PIN_A       = 3'h2;
	localparam logic [2:0] TRIG_PIN_B       = 3'h3;
	localparam logic [2:0] TRIG_TIMER_FIRST = 3'h4;
	localparam logic [2:0] CHAN_LAST        = 3'h7;
	localparam int         CHAN_COUNT       = 8;
	localparam logic [3:0] CONV_SCAN_RESOLUTION_CODE_FULL   = 4'hb;
	localparam logic [9:0] RES_FULL_MASK    = 10'h3ff;
	localparam logic [7:0] MASK_DEFAULT     = 8'h01;

	localparam int SYS_CLK_HZ      = 50_000_000;
	localparam int CONV_CLK_MAX_HZ = 4_500_000;
	// Smallest divisor keeping the conversion clock within its maximum.
	localparam int DIV_RECOMMENDED = (SYS_CLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ - 1;

	typedef enum logic {
		SEQ_IDLE,
		SEQ_CONVERT
	} seq_state_t;

	// ======================================================================
	// Helper functions
	function automatic logic [7:0] eff_mask(input logic [7:0] m);
		eff_mask = (m == '0) ? MASK_DEFAULT : m; // RULE_01
	endfunction

	// Next selected channel above cur, wrapping; starting from the last gives the lowest.
	function automatic logic [2:0] next_chan(input logic [7:0] m, input logic [2:0] cur);
		logic [2:0] c;
		logic       found;
		next_chan = cur;
		found = 1'b0;
		for (int i = 1; i <= CHAN_COUNT; i++) begin
			c = cur + i[2:0];
			if (!found && m[c]) begin
				next_chan = c;
				found = 1'b1;
			end
		end
	endfunction

	// Index of the last conversion clock of a conversion.
	function automatic logic [3:0] conv_last(input logic scan, input logic [2:0] code);
		conv_last = scan ? (CONV_SCAN_RESOLUTION_CODE_FULL - 4'h1 - {1'b0, code}) : (CONV_SCAN_RESOLUTION_CODE_FULL - 4'h1);
	endfunction

	// Bits of accuracy kept in the result for a resolution code.
	function automatic logic [9:0] res_keep(input logic [2:0] code);
		res_keep = RES_FULL_MASK << code;
	endfunction

endpackage

// >>> conv_ctl_if.sv
// Interface between the sequencer, its conversion clock divider and its trigger selector.
`timescale 1ns/10ps
`default_nettype none
interface conv_ctl_if;
	logic       run;
	logic [7:0] divisor;
	logic       tick;
	logic       conv_clk;
	logic [2:0] trig_src;
	logic       edge_rising;
	logic       scan_on;
	logic       hw_start;

	modport seq (output run, divisor, trig_src, edge_rising, scan_on,
		input tick, conv_clk, hw_start);
	modport div (input run, divisor, output tick, conv_clk);
	modport trig (input trig_src, edge_rising, scan_on, output hw_start);
endinterface
`default_nettype wire

// >>> conv_clock_div.sv
// Conversion clock divider, held in reset while no conversion runs.
`timescale 1ns/10ps
`default_nettype none
module conv_clock_div (
	input  wire logic  i_clk,
	input  wire logic  i_rst,
	conv_ctl_if.div    ctl
);
	typedef struct packed {
		logic [7:0] cnt;
		logic       conv_clk;
		logic [8:0] since;
	} div_regs_t;

	div_regs_t st_reg;
	div_regs_t st_next;

	// ======================================================================
	// Divide by divisor plus one
	assign ctl.tick = ctl.run && (st_reg.cnt == ctl.divisor); // RULE_04
	assign ctl.conv_clk = st_reg.conv_clk;

	always_comb begin
		st_next = st_reg;
		if (!ctl.run) begin
			st_next.cnt = '0;
		end else if (ctl.tick) begin
			st_next.cnt = '0;
		end else begin
			st_next.cnt = st_reg.cnt + 8'h01;
		end
		st_next.conv_clk = ctl.run && (st_next.cnt <= {1'b0, ctl.divisor[7:1]});
		st_next.since = (!ctl.run || ctl.tick) ? 9'h000 : st_reg.since + 9'h001;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ======================================================================
	// Checks
	AST_DIV_PERIOD: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_04
		ctl.tick && $stable(ctl.divisor) |-> st_reg.since == {1'b0, ctl.divisor})
		else $error("Conversion clock period differs from divisor plus one.");
endmodule // conv_clock_div
`default_nettype wire

// >>> conv_trigger_sel.sv
// Hardware trigger selection and edge detection for single conversions.
`timescale 1ns/10ps
`default_nettype none
module conv_trigger_sel (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic       i_pin_a,
	input  wire logic       i_pin_b,
	input  wire logic [3:0] i_timer_match,
	conv_ctl_if.trig        ctl
);
	typedef struct packed {
		logic [1:0] pin_meta;
		logic [1:0] pin_sync;
		logic       lvl_prev;
	} trig_regs_t;

	trig_regs_t st_reg;
	trig_regs_t st_next;
	logic       sel_sig;
	logic       lvl;
	logic       hw_code;

	always_comb begin
		st_next = st_reg;
		st_next.pin_meta = {i_pin_b, i_pin_a};
		st_next.pin_sync = st_reg.pin_meta;
		unique case (ctl.trig_src)
			adc_seq_pkg::TRIG_PIN_A: sel_sig = st_reg.pin_sync[0]; // RULE_14
			adc_seq_pkg::TRIG_PIN_B: sel_sig = st_reg.pin_sync[1]; // RULE_14
			adc_seq_pkg::TRIG_NONE, adc_seq_pkg::TRIG_NOW: sel_sig = 1'b0;
			default: sel_sig = i_timer_match[ctl.trig_src[1:0]]; // RULE_15
		endcase
		hw_code = ctl.trig_src >= adc_seq_pkg::TRIG_PIN_A;
		// A falling edge after the XOR is a falling edge, or a rising edge when inverted.
		lvl = sel_sig ^ ctl.edge_rising; // RULE_20 RULE_17
		st_next.lvl_prev = lvl;
	end

	assign ctl.hw_start = hw_code && !ctl.scan_on && st_reg.lvl_prev && !lvl; // RULE_16

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ======================================================================
	// Checks
	AST_TRIG_GATED: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_16
		ctl.hw_start |-> !ctl.scan_on && ctl.trig_src >= adc_seq_pkg::TRIG_PIN_A)
		else $error("Hardware trigger fired while scanning or for a software code.");
	AST_TRIG_EDGE: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_17
		ctl.hw_start && $stable(ctl.edge_rising) && $stable(ctl.trig_src)
		|-> (sel_sig == ctl.edge_rising) && ($past(sel_sig) != ctl.edge_rising))
		else $error("Hardware trigger fired on the wrong edge.");
	COV_TRIG_PIN: cover property (@(posedge i_clk) disable iff (i_rst)
		ctl.hw_start && ctl.trig_src == adc_seq_pkg::TRIG_PIN_A);
endmodule // conv_trigger_sel
`default_nettype wire

// >>> adc_control_sequencer.sv
// Top of the converter control sequencer: control register, scan and conversion timing.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module adc_control_sequencer (
	input  wire logic        I_CLK_SYS,
	input  wire logic        I_SYS_RST,
	input  wire logic [31:0] I_BUS_ADDR,
	input  wire logic [31:0] I_BUS_WDATA,
	input  wire logic        I_BUS_WR,
	input  wire logic        I_BUS_RD,
	output logic      [31:0] O_BUS_RDATA,
	input  wire logic        I_TRIG_PIN_A,
	input  wire logic        I_TRIG_PIN_B,
	input  wire logic        I_TIMER0_MATCH1,
	input  wire logic        I_TIMER0_MATCH3,
	input  wire logic        I_TIMER1_MATCH0,
	input  wire logic        I_TIMER1_MATCH1,
	input  wire logic [9:0]  I_CONV_DATA,
	output logic             O_CONV_CLK,
	output logic             O_CONV_POWERED,
	output logic             O_CONV_ACTIVE,
	output logic      [2:0]  O_CONV_CHANNEL,
	output logic      [1:0]  O_TEST_MODE,
	output logic             O_CONV_IRQ,
	output logic      [2:0]  O_RESULT_CHANNEL
);
	typedef struct packed {
		adc_seq_pkg::ctrl_t      ctrl;
		adc_seq_pkg::seq_state_t state;
		logic [2:0]              cur_chan;
		logic [3:0]              clk_cnt;
		logic                    conv_scan;
		logic [2:0]              conv_res;
		logic                    done;
		logic                    overrun;
		logic [2:0]              res_chan;
		logic [9:0]              res_data;
		logic [31:0]             rdata;
	} seq_regs_t;

	localparam seq_regs_t SEQ_RESET = '{
		ctrl:    adc_seq_pkg::ctrl_t'(adc_seq_pkg::CTRL_RESET),
		state:   adc_seq_pkg::SEQ_IDLE,
		default: '0
	};

	seq_regs_t          st_reg;
	seq_regs_t          st_next;
	adc_seq_pkg::ctrl_t wctrl;
	adc_seq_pkg::ctrl_t src;
	adc_seq_pkg::result_t res_view;
	logic               wr_ctrl;
	logic               rd_result;
	logic               busy;
	logic               finish;
	logic               start;

	conv_ctl_if ctl_bus ();

	// ======================================================================
	// Helper blocks
	conv_clock_div u_div (
		.i_clk (I_CLK_SYS),
		.i_rst (I_SYS_RST),
		.ctl   (ctl_bus)
	);

	conv_trigger_sel u_trig (
		.i_clk         (I_CLK_SYS),
		.i_rst         (I_SYS_RST),
		.i_pin_a       (I_TRIG_PIN_A),
		.i_pin_b       (I_TRIG_PIN_B),
		.i_timer_match ({I_TIMER1_MATCH1, I_TIMER1_MATCH0, I_TIMER0_MATCH3, I_TIMER0_MATCH1}),
		.ctl           (ctl_bus)
	);

	assign busy = (st_reg.state == adc_seq_pkg::SEQ_CONVERT);
	assign ctl_bus.run = busy;
	assign ctl_bus.divisor = st_reg.ctrl.conv_clock_divisor;
	assign ctl_bus.trig_src = st_reg.ctrl.trigger_source;
	assign ctl_bus.edge_rising = st_reg.ctrl.edge_rising;
	assign ctl_bus.scan_on = st_reg.ctrl.continuous_scan;

	// ======================================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		wctrl = adc_seq_pkg::ctrl_t'(I_BUS_WDATA & adc_seq_pkg::CTRL_WMASK);
		wr_ctrl = I_BUS_WR && (I_BUS_ADDR == adc_seq_pkg::CTRL_ADDR);
		rd_result = I_BUS_RD && (I_BUS_ADDR == adc_seq_pkg::RESULT_ADDR);
		finish = busy && ctl_bus.tick
			&& (st_reg.clk_cnt == adc_seq_pkg::conv_last(st_reg.conv_scan, st_reg.conv_res));

		res_view = '0;
		res_view.done = st_reg.done;
		res_view.overrun = st_reg.overrun;
		res_view.result_channel = st_reg.res_chan;
		res_view.data = st_reg.res_data;

		// Read data stand for the one cycle after the strobe; unmapped addresses read zero.
		st_next.rdata = '0;
		if (I_BUS_RD && I_BUS_ADDR == adc_seq_pkg::CTRL_ADDR) begin
			st_next.rdata = st_reg.ctrl;
		end else if (rd_result) begin
			st_next.rdata = res_view;
		end

		// Clears come first so that a finishing conversion in the same cycle wins.
		if (rd_result || wr_ctrl) begin
			st_next.done = 1'b0; // RULE_19
		end
		if (rd_result) begin
			st_next.overrun = 1'b0;
		end
		if (wr_ctrl) begin
			st_next.ctrl = wctrl;
		end

		if (finish) begin
			st_next.res_data = I_CONV_DATA & adc_seq_pkg::res_keep(st_reg.conv_res); // RULE_10
			st_next.res_chan = st_reg.cur_chan; // RULE_21
			st_next.done = 1'b1; // RULE_19
			if (st_reg.done && !rd_result && st_reg.conv_scan) begin
				st_next.overrun = 1'b1;
			end
			if (st_reg.ctrl.continuous_scan) begin
				// Back to back on the next selected input, wrapping past the highest.
				st_next.cur_chan = adc_seq_pkg::next_chan( // RULE_07 RULE_08 RULE_23 RULE_03
					adc_seq_pkg::eff_mask(st_reg.ctrl.channel_mask), st_reg.cur_chan);
				st_next.clk_cnt = '0;
				st_next.conv_scan = 1'b1;
				st_next.conv_res = st_reg.ctrl.scan_resolution_code; // RULE_10
			end else begin
				st_next.state = adc_seq_pkg::SEQ_IDLE; // RULE_09
			end
		end else if (busy && ctl_bus.tick) begin
			st_next.clk_cnt = st_reg.clk_cnt + 4'h1;
		end

		// A write with code 001 restarts; a scan write starts only from idle.
		start = 1'b0;
		src = st_reg.ctrl;
		if (wr_ctrl && wctrl.converter_powered) begin
			src = wctrl;
			if (wctrl.continuous_scan) begin
				start = !busy; // RULE_07
			end else begin
				start = (wctrl.trigger_source == adc_seq_pkg::TRIG_NOW); // RULE_13 RULE_12
			end
		end else if (!wr_ctrl && !busy && ctl_bus.hw_start && st_reg.ctrl.converter_powered) begin
			start = 1'b1; // RULE_14 RULE_15 RULE_06
		end
		if (start) begin
			st_next.state = adc_seq_pkg::SEQ_CONVERT;
			st_next.clk_cnt = '0;
			st_next.cur_chan = adc_seq_pkg::next_chan( // RULE_08 RULE_01
				adc_seq_pkg::eff_mask(src.channel_mask), adc_seq_pkg::CHAN_LAST);
			st_next.conv_scan = src.continuous_scan; // RULE_06
			st_next.conv_res = src.scan_resolution_code;
		end

		// Powering down abandons any conversion.
		if (!st_next.ctrl.converter_powered) begin
			st_next.state = adc_seq_pkg::SEQ_IDLE; // RULE_11
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_SYS_RST) begin
			st_reg <= SEQ_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	// ======================================================================
	// Outputs
	assign O_BUS_RDATA = st_reg.rdata;
	assign O_CONV_CLK = ctl_bus.conv_clk;
	assign O_CONV_POWERED = st_reg.ctrl.converter_powered; // RULE_11
	assign O_CONV_ACTIVE = busy;
	assign O_CONV_CHANNEL = st_reg.cur_chan;
	assign O_TEST_MODE = st_reg.ctrl.test_mode_field; // RULE_18
	assign O_CONV_IRQ = st_reg.done; // RULE_22
	assign O_RESULT_CHANNEL = st_reg.res_chan;

	// ======================================================================
	// Checks
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_SYS_RST);

	AST_MASK_ZERO: assert property ( // RULE_01
		$rose(busy) && st_reg.ctrl.channel_mask == 8'h00 |-> st_reg.cur_chan == 3'h0)
		else $error("Empty channel mask did not select input 0.");
	AST_SINGLE_LEN: assert property ( // RULE_06
		finish && !st_reg.conv_scan |-> st_reg.clk_cnt == 4'ha)
		else $error("Single conversion did not last 11 conversion clocks.");
	AST_SCAN_LEN: assert property ( // RULE_10
		finish && st_reg.conv_scan |-> st_reg.clk_cnt == 4'ha - {1'b0, st_reg.conv_res})
		else $error("Scan conversion length does not match resolution code.");
	AST_SCAN_NEXT: assert property ( // RULE_23
		finish && st_reg.ctrl.continuous_scan && !wr_ctrl |=> busy
		&& ((adc_seq_pkg::eff_mask(st_reg.ctrl.channel_mask) >> st_reg.cur_chan) & 8'h01) != 8'h00
		&& (st_reg.cur_chan > $past(st_reg.cur_chan)
		|| st_reg.cur_chan == adc_seq_pkg::next_chan(
		adc_seq_pkg::eff_mask(st_reg.ctrl.channel_mask), adc_seq_pkg::CHAN_LAST)))
		else $error("Scan did not move to the next selected input.");
	AST_SCAN_STOP: assert property ( // RULE_09
		busy && !st_reg.ctrl.continuous_scan && !finish && !wr_ctrl
		&& st_reg.ctrl.converter_powered |=> busy)
		else $error("Running conversion was cut short.");
	AST_STOP_AFTER: assert property ( // RULE_09
		finish && !st_reg.ctrl.continuous_scan && !start |=> !busy)
		else $error("Conversion repeated with scan bit clear.");
	AST_NO_START: assert property ( // RULE_12
		!busy && !wr_ctrl && st_reg.ctrl.trigger_source == adc_seq_pkg::TRIG_NONE |=> !busy)
		else $error("Conversion started with trigger code 000.");
	AST_SOFT_START: assert property ( // RULE_13
		wr_ctrl && wctrl.converter_powered && !wctrl.continuous_scan
		&& wctrl.trigger_source == adc_seq_pkg::TRIG_NOW |=> busy && st_reg.clk_cnt == 4'h0)
		else $error("Writing code 001 did not start a conversion.");
	AST_POWER_DOWN: assert property ( // RULE_11
		!st_reg.ctrl.converter_powered && !wr_ctrl |=> !busy && !O_CONV_POWERED)
		else $error("Converter ran while powered down.");
	AST_DONE_SET: assert property ( // RULE_19
		finish |=> st_reg.done && O_CONV_IRQ ##0 st_reg.res_chan == $past(st_reg.cur_chan))
		else $error("Finish did not set the flag and channel.");
	AST_DONE_CLEAR: assert property ( // RULE_19
		(rd_result || wr_ctrl) && !finish |=> !st_reg.done)
		else $error("Completion flag not cleared by read or write.");
	AST_IRQ_LEVEL: assert property ( // RULE_22
		st_reg.done [*2] |-> O_CONV_IRQ && $past(O_CONV_IRQ))
		else $error("Interrupt request dropped while flag is set.");

	COV_SOFT_DONE: cover property (wr_ctrl ##[1:300] finish);
	COV_SCAN_WRAP: cover property (finish && st_reg.conv_scan && st_next.cur_chan < st_reg.cur_chan);
	COV_OVERRUN: cover property (finish && st_reg.done && st_reg.conv_scan);
	COV_HW_START: cover property (!busy && ctl_bus.hw_start ##1 busy);
endmodule // adc_control_sequencer
`default_nettype wire

// >>> adc_cell_model.sv
// Behavioural model of the analog converter cell that supplies conversion results.
`timescale 1ns/10ps
`default_nettype none
module adc_cell_model (
	input  wire logic       i_clk,
	input  wire logic       i_active,
	input  wire logic [2:0] i_channel,
	output logic      [9:0] o_data
);
	// ======================================================================
	// Result source
	// While converting, the value follows the channel being converted.
	// While idle the lines toggle every cycle, so a stale sample never passes for a good one.
	initial o_data = 10'h000;
	always @(posedge i_clk) begin
		if (i_active) begin
			o_data <= {i_channel, i_channel, i_channel, 1'b1} ^ 10'h2a5;
		end else begin
			o_data <= ~o_data;
		end
	end
endmodule // adc_cell_model
`default_nettype wire

// >>> test_adc_control_sequencer.sv
// Self-checking testbench of the converter control sequencer.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin \
	samples_checked++; \
	if ((e) !== (g)) begin \
		err_count++; \
		$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
	end \
end
module test_adc_control_sequencer;
	logic        clk, rst, wr, rd, cclk, pwr, act, irq, prev_cclk;
	logic [31:0] addr, wdata, rdata, lfsr, v, w;
	logic [5:0]  trg;
	logic [7:0]  m;
	logic [2:0]  ch, rch, ec;
	logic [1:0]  tst;
	logic [9:0]  cdata;
	int          err_count, samples_checked, cyc, t0, d, len, last_rise, per;

	adc_control_sequencer i_dut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_BUS_ADDR(addr),
		.I_BUS_WDATA(wdata), .I_BUS_WR(wr), .I_BUS_RD(rd), .O_BUS_RDATA(rdata),
		.I_TRIG_PIN_A(trg[0]), .I_TRIG_PIN_B(trg[1]), .I_TIMER0_MATCH1(trg[2]),
		.I_TIMER0_MATCH3(trg[3]), .I_TIMER1_MATCH0(trg[4]), .I_TIMER1_MATCH1(trg[5]),
		.I_CONV_DATA(cdata), .O_CONV_CLK(cclk), .O_CONV_POWERED(pwr), .O_CONV_ACTIVE(act),
		.O_CONV_CHANNEL(ch), .O_TEST_MODE(tst), .O_CONV_IRQ(irq), .O_RESULT_CHANNEL(rch));
	adc_cell_model i_cell (.i_clk(clk), .i_active(act), .i_channel(ch), .o_data(cdata));

	// ======================================================================
	// Clock, cycle count and conversion clock period monitor
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		prev_cclk <= cclk;
		if (cclk && !prev_cclk) begin
			per <= cyc - last_rise;
			last_rise <= cyc;
		end
	end

	// ======================================================================
	// Helpers
	function automatic logic [31:0] nx(input logic [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] mk(input logic [7:0] mm, input logic [7:0] dv,
		input logic sc, input logic [2:0] rs, input logic [2:0] tg, input logic eg);
		mk = {4'h0, eg, tg, 2'h0, 1'b1, 1'b0, rs, sc, dv, mm};
	endfunction
	function automatic logic [9:0] ed(input logic [2:0] c, input logic [2:0] rs);
		ed = ({c, c, c, 1'b1} ^ 10'h2a5) & (10'h3ff << rs);
	endfunction
	function automatic logic [2:0] nc(input logic [7:0] mm, input logic [2:0] c);
		nc = c;
		for (int i = 8; i >= 1; i--) begin
			if (mm[(c + i) % 8]) begin
				nc = 3'((c + i) % 8);
			end
		end
	endfunction

	task automatic report_and_stop();
		$display("Checks made %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wrt(input logic [31:0] a, input logic [31:0] dt);
		@(posedge clk);
		addr <= a;
		wdata <= dt;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdt(input logic [31:0] a, output logic [31:0] dt);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 dt = rdata;
	endtask
	task automatic wirq(input int lim);
		int n;
		n = 0;
		while (irq !== 1'b1) begin
			@(posedge clk);
			#1 n++;
			if (n > lim) begin
				`CHK("irq_wait", 1'b1, irq)
				report_and_stop();
			end
		end
	endtask
	task automatic single(input logic [7:0] mm, input logic [2:0] c);
		d = (mm == 8'h00) ? adc_seq_pkg::DIV_RECOMMENDED : 1 + lfsr[1:0];
		lfsr = nx(lfsr);
		wrt(adc_seq_pkg::CTRL_ADDR, mk(mm, 8'(d), 1'b0, 3'h0, 3'h1, 1'b0));
		#1 t0 = cyc;
		`CHK("conv_chan", c, ch)
		wirq(400);
		len = cyc - t0 - 11 * (d + 1);
		`CHK("single_len", 1'b1, (len == 0 || len == 1))
		`CHK("conv_clk_period", d + 1, per)
		rdt(adc_seq_pkg::RESULT_ADDR, v);
		`CHK("done", 1'b1, v[31])
		`CHK("result_chan", c, v[26:24])
		`CHK("result_chan_out", c, rch)
		`CHK("result_data", ed(c, 3'h0), v[15:6])
		`CHK("irq_read_clear", 1'b0, irq)
	endtask
	task automatic scan(input logic [7:0] mm, input logic [2:0] rs);
		d = 1 + lfsr[1:0];
		lfsr = nx(lfsr);
		ec = nc(mm, 3'h7);
		wrt(adc_seq_pkg::CTRL_ADDR, mk(mm, 8'(d), 1'b1, rs, 3'h0, 1'b0));
		for (int j = 0; j < 10; j++) begin
			wirq(200);
			if (j > 0) `CHK("scan_len", (11 - rs) * (d + 1), cyc - t0)
			t0 = cyc;
			rdt(adc_seq_pkg::RESULT_ADDR, v);
			`CHK("scan_chan", ec, v[26:24])
			`CHK("scan_data", ed(ec, rs), v[15:6])
			ec = nc(mm, ec);
		end
		wrt(adc_seq_pkg::CTRL_ADDR, mk(mm, 8'(d), 1'b0, rs, 3'h0, 1'b0));
		wirq(200);
		rdt(adc_seq_pkg::RESULT_ADDR, v);
		`CHK("last_chan", ec, v[26:24])
		repeat (40) @(posedge clk);
		#1 `CHK("scan_stopped", 2'b00, {irq, act})
	endtask

	// ======================================================================
	// Main sequence
	initial begin
		rst = 1'b1;
		{wr, rd, prev_cclk} = 3'b000;
		addr = 32'h0;
		wdata = 32'h0;
		trg = 6'h00;
		lfsr = 32'hd158;
		{cyc, last_rise, per, err_count, samples_checked} = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdt(adc_seq_pkg::CTRL_ADDR, v);
		`CHK("ctrl_reset", 32'h0000_0001, v)
		`CHK("powered_reset", 1'b0, pwr)
		rdt(32'he003_4008, v);
		`CHK("unmapped_read", 32'h0, v)
		for (int t = 0; t < 4; t++) begin
			w = {4'hf, 4'h0, 2'(t), 2'h3, lfsr[2:0], 1'b0, lfsr[31:16]};
			lfsr = nx(lfsr);
			wrt(adc_seq_pkg::CTRL_ADDR, w);
			rdt(adc_seq_pkg::CTRL_ADDR, v);
			`CHK("ctrl_readback", w & adc_seq_pkg::CTRL_WMASK, v)
			`CHK("test_mode", 2'(t), tst)
			`CHK("powered", 1'b1, pwr)
		end
		wrt(adc_seq_pkg::CTRL_ADDR, 32'h0);
		#1 `CHK("powered_down", 1'b0, pwr)
		$display("TEST registers done");
		for (int i = 0; i < 4; i++) begin
			ec = lfsr[2:0];
			lfsr = nx(lfsr);
			single(8'h01 << ec, ec);
		end
		single(8'h00, 3'h0);
		$display("TEST single done");
		for (int k = 2; k < 8; k++) begin
			for (int e = 0; e < 2; e++) begin
				trg[k - 2] <= ~e[0];
				repeat (4) @(posedge clk);
				wrt(adc_seq_pkg::CTRL_ADDR, mk(8'h04, 8'h01, 1'b0, 3'h0, 3'(k), e[0]));
				repeat (6) @(posedge clk);
				#1 `CHK("trig_idle", 1'b0, act)
				trg[k - 2] <= e[0];
				wirq(60);
				wrt(adc_seq_pkg::CTRL_ADDR, mk(8'h04, 8'h01, 1'b0, 3'h0, 3'h0, 1'b0));
				#1 `CHK("done_write_clear", 1'b0, irq)
			end
		end
		trg <= 6'h3f;
		repeat (6) @(posedge clk);
		trg <= 6'h00;
		repeat (8) @(posedge clk);
		#1 `CHK("code_none", 1'b0, act)
		$display("TEST triggers done");
		scan(8'hff, 3'h7);
		m = lfsr[7:0] | 8'h01;
		lfsr = nx(lfsr);
		scan(m, lfsr[2:0]);
		$display("TEST scan done");
		report_and_stop();
	end
endmodule // test_adc_control_sequencer
`default_nettype wire
